// ===== src/daa_interrupt_watchdog_control.v
`timescale 1ns/1ps
`include "daa_irq_regs.vh"
module daa_interrupt_watchdog_control #(
  parameter WDT_CYCLES = `WDT_CYCLES
)(
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Detector inputs from other clock domains
  input wire ring_active,
  input wire rx_overload_evt,
  input wire frame_lock_lost,
  input wire billing_tone_evt,
  input wire supply_dropout_evt,
  input wire [4:0] loop_current_value,
  input wire tip_ground_status,
  input wire [7:0] line_voltage_value,
  // Monitor stream input
  input wire monitor_bit,
  // Outputs
  output reg monitor_or_irq_pin,
  output reg off_hook_ctl,
  output reg hybrid_connect,
  output reg receive_path_on
);
// ----------------------------------------
// Synchronisers
// ----------------------------------------
wire [19:0] raw_in;
reg [19:0] sync1_q;
reg [19:0] sync2_q;
reg [19:0] prev_q;
assign raw_in = {monitor_bit, line_voltage_value[`LVS_TOP],
  tip_ground_status, loop_current_value, supply_dropout_evt,
  billing_tone_evt, frame_lock_lost, rx_overload_evt, ring_active,
  7'h00};
// First stage feeds only the second; nothing else reads it
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sync1_q <= `SYNC_RESET;
  end
  else
  begin
    sync1_q <= raw_in;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sync2_q <= `SYNC_RESET;
  end
  else
  begin
    sync2_q <= sync1_q;
  end
end
// Last settled sample, for edge detection
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prev_q <= `SYNC_RESET;
  end
  else
  begin
    prev_q <= sync2_q;
  end
end
wire s_mon = sync2_q[`SYN_MON];
wire s_lvs = sync2_q[`SYN_LVS];
wire s_tip = sync2_q[`SYN_TIP];
wire [4:0] s_lcs = sync2_q[`SYN_LCS_HI:`SYN_LCS_LO];
wire s_drop = sync2_q[`SYN_DROP];
wire s_bill = sync2_q[`SYN_BILL];
wire s_frame = sync2_q[`SYN_FRAME];
wire s_ovl = sync2_q[`SYN_OVL];
wire s_ring = sync2_q[`SYN_RING];
wire p_lvs = prev_q[`SYN_LVS];
wire p_tip = prev_q[`SYN_TIP];
wire p_lcs_full = (prev_q[`SYN_LCS_HI:`SYN_LCS_LO] == `LCS_FULL);
wire p_drop = prev_q[`SYN_DROP];
wire p_bill = prev_q[`SYN_BILL];
wire p_frame = prev_q[`SYN_FRAME];
wire p_ovl = prev_q[`SYN_OVL];
wire p_ring = prev_q[`SYN_RING];
// ----------------------------------------
// Bus decode
// ----------------------------------------
wire acc = psel & penable & pready;
wire wr = acc & pwrite;
wire hit_ctl = (paddr == `ADDR_CONTROL_TWO);
wire hit_mask = (paddr == `ADDR_MASK);
wire hit_src = (paddr == `ADDR_SOURCE);
wire hit_oh = (paddr == `ADDR_OFF_HOOK);
wire hit_any = hit_ctl | hit_mask | hit_src | hit_oh;
// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] ctl_q;
reg [7:0] mask_q;
reg [7:0] src_q;
reg [7:0] src_d;
reg [7:0] ctl_d;
reg [7:0] evt;
reg oh_q;
reg [31:0] wdt_q;
reg wdt_fire;
// Ring end only counts when the ring mode bit is set
wire ring_start = s_ring & ~p_ring;
wire ring_end = ~s_ring & p_ring & ctl_q[`CTL_RING_MODE];
always @*
begin
  evt = 8'h00;
  evt[`SRC_RING] = ring_start | ring_end;
  evt[`SRC_OVL] = s_ovl & ~p_ovl;
  evt[`SRC_FRAME] = s_frame & ~p_frame;
  evt[`SRC_BILL] = s_bill & ~p_bill;
  evt[`SRC_DROP] = s_drop & ~p_drop;
  evt[`SRC_LOOP] = (s_lcs == `LCS_FULL) & ~p_lcs_full;
  evt[`SRC_TIP] = s_tip & ~p_tip;
  evt[`SRC_POL] = s_lvs ^ p_lvs;
  // Event wins over a same-cycle clear
  src_d = src_q;
  if (wr && hit_src)
  begin
    src_d = src_q & pwdata[7:0];
  end
  src_d = src_d | evt;
  // Sticky arm bit
  ctl_d = ctl_q;
  if (wr && hit_ctl)
  begin
    ctl_d = pwdata[7:0] & `CTL_WMASK;
    ctl_d[`CTL_WDT] = ctl_q[`CTL_WDT] | pwdata[`CTL_WDT];
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    ctl_q <= `CTL_RESET;
  end
  else
  begin
    ctl_q <= ctl_d;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    src_q <= `SRC_RESET;
  end
  else
  begin
    src_q <= src_d;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    mask_q <= `MASK_RESET;
  end
  else if (wr && hit_mask)
  begin
    mask_q <= pwdata[7:0];
  end
end
// Host write after timeout works normally
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    oh_q <= 1'b0;
  end
  else if (wr && hit_oh)
  begin
    oh_q <= pwdata[`OH_BIT];
  end
  else if (wdt_fire)
  begin
    oh_q <= 1'b0;
  end
end
// ----------------------------------------
// Watchdog
// ----------------------------------------
wire wdt_hit = ctl_q[`CTL_WDT] && !acc && (wdt_q >= WDT_CYCLES - 1);
// Reads restart the count too, so polling alone keeps the line up
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    wdt_q <= `WDT_RESET;
  end
  else if (acc || !ctl_q[`CTL_WDT])
  begin
    wdt_q <= `WDT_RESET;
  end
  else if (wdt_hit)
  begin
    wdt_q <= `WDT_RESET;
  end
  else
  begin
    wdt_q <= wdt_q + 32'h0000_0001;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    wdt_fire <= 1'b0;
  end
  else
  begin
    wdt_fire <= wdt_hit;
  end
end
// ----------------------------------------
// APB answer
// ----------------------------------------
wire irq_any = |(src_q & mask_q);
wire irq_lvl = irq_any ~^ ctl_q[`CTL_POL];
reg [31:0] rd_d;
// Latched in setup, so data stands with pready
always @*
begin
  rd_d = `RD_ZERO;
  if (hit_ctl)
  begin
    rd_d = {24'h00_0000, ctl_q};
  end
  else if (hit_mask)
  begin
    rd_d = {24'h00_0000, mask_q};
  end
  else if (hit_src)
  begin
    rd_d = {24'h00_0000, src_q};
  end
  else if (hit_oh)
  begin
    rd_d = {31'h0000_0000, oh_q};
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    prdata <= `RD_ZERO;
  end
  else if (psel && !penable && !pwrite)
  begin
    prdata <= rd_d;
  end
  else
  begin
    prdata <= `RD_ZERO;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pready <= 1'b0;
  end
  else
  begin
    pready <= psel & ~penable;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    pslverr <= 1'b0;
  end
  else
  begin
    pslverr <= psel & ~penable & ~hit_any;
  end
end
// ----------------------------------------
// Pin outputs
// ----------------------------------------
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    monitor_or_irq_pin <= 1'b0;
  end
  else if (ctl_q[`CTL_PIN_SEL])
  begin
    monitor_or_irq_pin <= irq_lvl;
  end
  else
  begin
    monitor_or_irq_pin <= s_mon;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    off_hook_ctl <= 1'b0;
  end
  else
  begin
    off_hook_ctl <= oh_q;
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    hybrid_connect <= 1'b0;
  end
  else
  begin
    hybrid_connect <= ctl_q[`CTL_HYBRID];
  end
end
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    receive_path_on <= 1'b0;
  end
  else
  begin
    receive_path_on <= ctl_q[`CTL_RX];
  end
end
endmodule // daa_interrupt_watchdog_control

// ===== src/daa_irq_regs.vh
`ifndef DAA_IRQ_REGS_VH
`define DAA_IRQ_REGS_VH
// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define REG_IDX_CONTROL_TWO 8'h02
`define REG_IDX_MASK 8'h03
`define REG_IDX_SOURCE 8'h04
`define REG_IDX_OFF_HOOK 8'h05
`define ADDR_CONTROL_TWO 12'h008
`define ADDR_MASK 12'h00C
`define ADDR_SOURCE 12'h010
`define ADDR_OFF_HOOK 12'h014
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CTL_PIN_SEL 7
`define CTL_POL 6
`define CTL_WDT 4
`define CTL_RING_MODE 2
`define CTL_HYBRID 1
`define CTL_RX 0
`define CTL_WMASK 8'hD7
`define CTL_RESET 8'h03
`define MASK_RESET 8'h00
`define SRC_RING 7
`define SRC_OVL 6
`define SRC_FRAME 5
`define SRC_BILL 4
`define SRC_DROP 3
`define SRC_RESET 8'h00
`define SRC_LOOP 2
`define SRC_TIP 1
`define SRC_POL 0
`define OH_BIT 0
`define LVS_TOP 7
`define LCS_FULL 5'h1F
// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define SYN_MON 19
`define SYN_LVS 18
`define SYN_TIP 17
`define SYN_LCS_HI 16
`define SYN_LCS_LO 12
`define SYN_DROP 11
`define SYN_BILL 10
`define SYN_FRAME 9
`define SYN_OVL 8
`define SYN_RING 7
`define SYNC_RESET 20'h0_0000
`define RD_ZERO 32'h0000_0000
`define WDT_RESET 32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define WDT_TIME_MS 4000
`define CLK_KHZ 50000
`define WDT_CYCLES (`WDT_TIME_MS * `CLK_KHZ)
`endif

// ===== tb/daa_chk.sv
`timescale 1ns/1ps
module daa_chk #(parameter W = 50)(
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire monitor_or_irq_pin,
  input wire off_hook_ctl,
  input wire hybrid_connect,
  input wire receive_path_on
);
  // Shadow of pin controls; idle counts cycles since last access
  reg [1:0] pin_q;
  reg [7:0] mask_q;
  integer idle_q;
  wire wr = pready && pwrite;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q <= 2'b00;
      mask_q <= 8'h00;
      idle_q <= 0;
    end
    else
    begin
      idle_q <= pready ? 0 : idle_q + 1;
      if (wr && paddr == 12'h008)
        pin_q <= pwdata[7:6];
      if (wr && paddr == 12'h00C)
        mask_q <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence quiet_s;
    (pin_q[1] && mask_q == 8'h00 && $stable(pin_q[0]))[*3];
  endsequence
  a_ready_one: assert property (setup_s |=> pready)
    else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_map: assert property (pready |-> pslverr ==
    !(paddr inside {12'h008, 12'h00C, 12'h010, 12'h014}))
    else $error("bad slverr");
  a_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("upper bits set");
  a_resv_zero: assert property (
    pready && !pwrite && paddr == 12'h008 |-> !prdata[5] && !prdata[3])
    else $error("reserved bit set");
  a_path_follow: assert property (
    wr && paddr == 12'h008 |-> ##2 receive_path_on == $past(pwdata[0], 2)
    && hybrid_connect == $past(pwdata[1], 2)) else $error("path bits");
  a_wdt_idle: assert property (
    $fell(off_hook_ctl) && !$past(pready) && !$past(pready, 2)
    |-> idle_q >= W) else $error("early timeout");
  a_pin_idle: assert property (
    quiet_s |-> monitor_or_irq_pin == !pin_q[0]) else $error("pin level");
endmodule // daa_chk
bind daa_interrupt_watchdog_control daa_chk #(.W(WDT_CYCLES)) i_chk (.*);

// ===== tb/line_model.sv
`timescale 1ns/1ps
module line_model(
  // Command
  input wire [7:0] ev,
  // Detector lines
  output wire ring_active,
  output wire rx_overload_evt,
  output wire frame_lock_lost,
  output wire billing_tone_evt,
  output wire supply_dropout_evt,
  output wire [4:0] loop_current_value,
  output wire tip_ground_status,
  output wire [7:0] line_voltage_value
);
  assign {ring_active, rx_overload_evt, frame_lock_lost} = ev[7:5];
  assign {billing_tone_evt, supply_dropout_evt} = ev[4:3];
  assign loop_current_value = {5{ev[2]}};
  assign tip_ground_status = ev[1];
  // Low bits fixed so only the top bit moves
  assign line_voltage_value = {ev[0], 7'h55};
endmodule // line_model

// ===== tb/daa_interrupt_watchdog_control_test.sv
`timescale 1ns/1ps
module daa_interrupt_watchdog_control_test;
  localparam W = 50;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg monitor_bit = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [7:0] ev = 8'h00;
  reg [7:0] rnd = 8'h32;
  reg [7:0] exp_q[$];
  integer err_count = 0;
  integer tests_run = 0;
  integer n;
  integer k;
  wire [31:0] prdata;
  wire pready, pslverr, monitor_or_irq_pin, off_hook_ctl, hybrid_connect;
  wire receive_path_on, ring_active, rx_overload_evt, frame_lock_lost;
  wire billing_tone_evt, supply_dropout_evt, tip_ground_status;
  wire [4:0] loop_current_value;
  wire [7:0] line_voltage_value;
  always #10 pclk = ~pclk;
  daa_interrupt_watchdog_control #(.WDT_CYCLES(W))
    i_daa_interrupt_watchdog_control (.*);
  line_model i_line_model (.*);
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task chk(input [31:0] e, input [31:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  end
  endtask
  // Request held until pready seen at a rising edge
  task xfer(input [11:0] a, input w, input [7:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
      err_count = err_count + 1;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task rd(input [11:0] a, input [7:0] e);
  begin
    exp_q.push_back(e);
    xfer(a, 1'b0, 8'h00);
  end
  endtask
  task results;
  begin
    if (exp_q.size() != 0)
      err_count = err_count + 1;
    $display("err_count=%0d tests_run=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  always @(posedge pclk)
    if (pready && penable && !pwrite && exp_q.size() > 0)
      chk({24'h00_0000, exp_q.pop_front()}, prdata);
  initial
  begin
    #50000;
    err_count = err_count + 1;
    results;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h008, 8'h03);
    rd(12'h00C, 8'h00);
    chk({hybrid_connect, receive_path_on}, 3);
    xfer(12'h008, 1'b1, 8'hFF);
    rd(12'h008, 8'hD7);
    xfer(12'h008, 1'b1, 8'h80);
    rd(12'h008, 8'h90);
    chk({hybrid_connect, receive_path_on}, 0);
    ev <= 8'hFF;
    repeat (8) @(posedge pclk);
    chk(monitor_or_irq_pin, 1);
    rd(12'h010, 8'hFF);
    xfer(12'h00C, 1'b1, 8'hFF);
    repeat (3) @(posedge pclk);
    chk(monitor_or_irq_pin, 0);
    xfer(12'h008, 1'b1, 8'hC0);
    repeat (3) @(posedge pclk);
    chk(monitor_or_irq_pin, 1);
    ev <= 8'h00;
    repeat (8) @(posedge pclk);
    xfer(12'h010, 1'b1, 8'h00);
    rd(12'h010, 8'h00);
    chk(monitor_or_irq_pin, 0);
    rnd = lfsr(rnd);
    xfer(12'h00C, 1'b1, rnd);
    rd(12'h00C, rnd);
    for (k = 0; k < 2; k = k + 1)
    begin
      xfer(12'h008, 1'b1, {5'h12, k[0], 2'b00});
      ev <= 8'h80;
      repeat (8) @(posedge pclk);
      xfer(12'h010, 1'b1, 8'h00);
      ev <= 8'h00;
      repeat (8) @(posedge pclk);
      rd(12'h010, {k[0], 7'h00});
      xfer(12'h010, 1'b1, 8'h00);
    end
    xfer(12'h014, 1'b1, 8'h01);
    repeat (4)
    begin
      repeat (W / 2) @(posedge pclk);
      rd(12'h014, 8'h01);
    end
    repeat (W + 8) @(posedge pclk);
    chk(off_hook_ctl, 0);
    xfer(12'h014, 1'b1, 8'h01);
    repeat (2) @(posedge pclk);
    chk(off_hook_ctl, 1);
    rd(12'h020, 8'h00);
    repeat (2) @(posedge pclk);
    results;
  end
endmodule // daa_interrupt_watchdog_control_test
